// [ivs_pkg.sv]
// Package for the interrupt vectoring and stacking block: vectors, codes, carriers.
// Assumes an 8-bit CPU with a 16-bit address space and vectors at the top of memory.
package ivs_pkg;
    // Vector addresses, high byte at the even address
    localparam logic [15:0] VEC_SERIAL = 16'hffd6;
    localparam logic [15:0] VEC_SPI = 16'hffd8;
    localparam logic [15:0] VEC_PEDGE = 16'hffda;
    localparam logic [15:0] VEC_POVF = 16'hffdc;
    localparam logic [15:0] VEC_TOVF = 16'hffde;
    localparam logic [15:0] VEC_IC4OC5 = 16'hffe0;
    localparam logic [15:0] VEC_OC4 = 16'hffe2;
    localparam logic [15:0] VEC_OC3 = 16'hffe4;
    localparam logic [15:0] VEC_OC2 = 16'hffe6;
    localparam logic [15:0] VEC_OC1 = 16'hffe8;
    localparam logic [15:0] VEC_IC3 = 16'hffea;
    localparam logic [15:0] VEC_IC2 = 16'hffec;
    localparam logic [15:0] VEC_IC1 = 16'hffee;
    localparam logic [15:0] VEC_RTI = 16'hfff0;
    localparam logic [15:0] VEC_IRQ = 16'hfff2;
    localparam logic [15:0] VEC_NMI = 16'hfff4;
    localparam logic [15:0] VEC_SWI = 16'hfff6;
    localparam logic [15:0] VEC_ILLOP = 16'hfff8;
    localparam logic [15:0] VEC_WDOG = 16'hfffa;
    localparam logic [15:0] VEC_CLKMON = 16'hfffc;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] ADDR_ONE = 16'h0001;
    localparam logic [3:0] PSEL_RESET = 4'h6;
    localparam logic [3:0] PSEL_RSVD = 4'h5;
    localparam logic [3:0] STACK_LAST = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Mask bit positions in the condition code byte
    localparam int I_BIT = 4;
    localparam int X_BIT = 6;
    // Maskable source indices in fixed priority order, 0 highest
    localparam int NMASK = 15;
    localparam int M_IRQ = 0;
    localparam int M_SERIAL = 14;
    // Promotion code per fixed-order index
    localparam logic [3:0] PSEL_OF [NMASK] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
        4'hd, 4'he, 4'hf, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
    localparam logic [15:0] VEC_OF [NMASK] = '{VEC_IRQ, VEC_RTI, VEC_IC1, VEC_IC2, VEC_IC3,
        VEC_OC1, VEC_OC2, VEC_OC3, VEC_OC4, VEC_IC4OC5, VEC_TOVF, VEC_POVF, VEC_PEDGE,
        VEC_SPI, VEC_SERIAL};

    // Register set that is stacked
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] iy;
        logic [15:0] ix;
        logic [7:0] accumulatorA;
        logic [7:0] accumulatorB;
        logic [7:0] conditionCodeRegister;
    } ivs_regs_t;

    // Raw peripheral flags, fixed-order index except serial group
    typedef struct packed {
        logic irq;
        logic rti;
        logic [3:1] capture;
        logic [4:1] compare;
        logic capture4Compare5;
        logic timerOverflow;
        logic pulseOverflow;
        logic pulseEdge;
        logic spiDone;
        logic receiveFull;
        logic overrun;
        logic transmitEmpty;
        logic transmitComplete;
        logic idleLine;
    } ivs_flags_t;

    // Local enables
    typedef struct packed {
        logic periodicTickIrqEnable;
        logic [3:1] captureIrqEnable;
        logic [4:1] compareIrqEnable;
        logic capture4Compare5IrqEnable;
        logic timerOverflowIrqEnable;
        logic pulseOverflowIrqEnable;
        logic pulseEdgeIrqEnable;
        logic spiDoneIrqEnable;
        logic receiveIrqEnable;
        logic transmitEmptyIrqEnable;
        logic transmitCompleteIrqEnable;
        logic idleLineIrqEnable;
    } ivs_enables_t;

    typedef enum logic [2:0] {
        IVS_IDLE = 3'b000,
        IVS_WAIT = 3'b001,
        IVS_PUSH = 3'b010,
        IVS_VECHI = 3'b011,
        IVS_VECLO = 3'b100,
        IVS_POP = 3'b101
    } ivs_state_t;
endpackage

// [ivs_vector_stack.sv]
// Interrupt recognition, vector choice, register stacking and unstacking.
// Assumes a CPU sequencer that pulses instruction-end, return and trap strobes,
// and a byte memory port that completes each access in the cycle it is asserted.
// What this block does
// [R1] Maskable requests accepted only with I clear
// [R2] Illegal opcode, software trap, NMI ignore I
// [R3] Twenty-five sources share twenty-one vectors
// [R4] Status read then data read clears receive-full
// [R5] Serial requests share one vector, locally gated
// [R6] SPI done gated by its enable
// [R7] Pulse edge and overflow, own enables
// [R8] Timer overflow, capture4/compare5, own vectors
// [R9] Compare 4..1 own vectors and enables
// [R10] Capture 3..1 own vectors and enables
// [R11] Highest pending source vector; RTI, IRQ, NMI, SWI
// [R12] Illegal, watchdog, clock monitor, reset vectors
// [R13] Recognizable once local and global masks permit
// [R14] Service starts when current instruction ends
// [R15] Push PC, Y, X, A, B, condition codes
// [R16] After condition code push set I; X for NMI
// [R17] Return pops in reverse order
// [R18] Priority select promotes one maskable; reset selects IRQ
// [R19] Maskable entry leaves X unchanged
// [R20] Stack pointer moves one per byte
// [R21] Vector read high byte first, loads PC
`timescale 1ns/10ps
module ivs_vector_stack (
    input wire logic mclk,
    input wire logic rstn,
    input wire ivs_pkg::ivs_flags_t flags,
    input wire ivs_pkg::ivs_enables_t enables,
    input wire logic nonmaskablePinRequest,
    input wire logic illegalOpcode,
    input wire logic softwareInterrupt,
    input wire logic watchdogFail,
    input wire logic watchdogDisable,
    input wire logic clockMonitorFail,
    input wire logic clockMonitorEnable,
    input wire logic powerOnReset,
    input wire logic [3:0] prioritySelect,
    input wire logic prioritySelectWrite,
    input wire logic serialStatusRead,
    input wire logic serialDataRead,
    input wire logic instructionEnd,
    input wire logic returnFromInterrupt,
    input wire ivs_pkg::ivs_regs_t cpuRegs,
    input wire logic [15:0] stackPointer,
    input wire logic [7:0] memReadData,
    output logic requestPending,
    output logic busy,
    output logic memWrite,
    output logic memRead,
    output logic [15:0] memAddr,
    output logic [7:0] memWriteData,
    output logic loadRegs,
    output ivs_pkg::ivs_regs_t newRegs,
    output logic [15:0] newStackPointer,
    output logic [3:0] prioritySelectOut,
    output logic receiveFullClear
);
    ivs_pkg::ivs_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [15:0] sp_ff, nxt_sp;
    logic [15:0] vec_ff, nxt_vec;
    logic nmiEntry_ff, nxt_nmiEntry;
    ivs_pkg::ivs_regs_t regs_ff, nxt_regs;
    logic load_ff, nxt_load;
    logic [3:0] psel_ff, nxt_psel;
    logic statusSeen_ff, nxt_statusSeen;
    logic [ivs_pkg::NMASK-1:0] maskReq;
    logic serialReq;
    logic resetReq;
    logic iBit;
    logic xBit;
    logic [15:0] pickVec;
    logic pickNmi;
    logic anyReq;

    // Byte of the register image at a stack slot, slot 0 is PC low
    function automatic logic [7:0] slotByte(input ivs_pkg::ivs_regs_t r, input logic [3:0] s);
        logic [7:0] b;
        b = r.conditionCodeRegister;
        unique case (s)
            4'h0: b = r.pc[7:0];
            4'h1: b = r.pc[15:8];
            4'h2: b = r.iy[7:0];
            4'h3: b = r.iy[15:8];
            4'h4: b = r.ix[7:0];
            4'h5: b = r.ix[15:8];
            4'h6: b = r.accumulatorA;
            4'h7: b = r.accumulatorB;
            default: b = r.conditionCodeRegister;
        endcase
        return b;
    endfunction

    // Register image with one stack slot replaced
    function automatic ivs_pkg::ivs_regs_t setSlot(input ivs_pkg::ivs_regs_t r,
            input logic [3:0] s, input logic [7:0] v);
        ivs_pkg::ivs_regs_t o;
        o = r;
        unique case (s)
            4'h0: o.pc[7:0] = v;
            4'h1: o.pc[15:8] = v;
            4'h2: o.iy[7:0] = v;
            4'h3: o.iy[15:8] = v;
            4'h4: o.ix[7:0] = v;
            4'h5: o.ix[15:8] = v;
            4'h6: o.accumulatorA = v;
            4'h7: o.accumulatorB = v;
            default: o.conditionCodeRegister = v;
        endcase
        return o;
    endfunction

    assign iBit = cpuRegs.conditionCodeRegister[ivs_pkg::I_BIT];
    assign xBit = cpuRegs.conditionCodeRegister[ivs_pkg::X_BIT];

    // Local gating of each maskable source except IRQ, fixed priority order
    assign serialReq = ((flags.receiveFull | flags.overrun) & enables.receiveIrqEnable)
        | (flags.transmitEmpty & enables.transmitEmptyIrqEnable)
        | (flags.transmitComplete & enables.transmitCompleteIrqEnable)
        | (flags.idleLine & enables.idleLineIrqEnable); // [R5]
    assign maskReq = {serialReq,
        flags.spiDone & enables.spiDoneIrqEnable, // [R6]
        flags.pulseEdge & enables.pulseEdgeIrqEnable, // [R7]
        flags.pulseOverflow & enables.pulseOverflowIrqEnable, // [R7]
        flags.timerOverflow & enables.timerOverflowIrqEnable, // [R8]
        flags.capture4Compare5 & enables.capture4Compare5IrqEnable, // [R8]
        flags.compare[4] & enables.compareIrqEnable[4], // [R9]
        flags.compare[3] & enables.compareIrqEnable[3],
        flags.compare[2] & enables.compareIrqEnable[2],
        flags.compare[1] & enables.compareIrqEnable[1],
        flags.capture[3] & enables.captureIrqEnable[3], // [R10]
        flags.capture[2] & enables.captureIrqEnable[2],
        flags.capture[1] & enables.captureIrqEnable[1],
        flags.rti & enables.periodicTickIrqEnable, // [R11]
        flags.irq}; // [R11]

    assign resetReq = powerOnReset | clockMonitorFail & clockMonitorEnable
        | watchdogFail & ~watchdogDisable;

    // Priority resolution; non-maskables first, then promoted, then fixed order
    always_comb begin
        pickVec = ivs_pkg::VEC_RESET;
        pickNmi = 1'b0;
        anyReq = 1'b1;
        if (powerOnReset) begin
            pickVec = ivs_pkg::VEC_RESET; // [R12]
        end else if (clockMonitorFail & clockMonitorEnable) begin
            pickVec = ivs_pkg::VEC_CLKMON; // [R12]
        end else if (watchdogFail & ~watchdogDisable) begin
            pickVec = ivs_pkg::VEC_WDOG; // [R12]
        end else if (nonmaskablePinRequest & ~xBit) begin
            pickVec = ivs_pkg::VEC_NMI; // [R2] [R11]
            pickNmi = 1'b1;
        end else if (illegalOpcode) begin
            pickVec = ivs_pkg::VEC_ILLOP; // [R2] [R12]
        end else if (softwareInterrupt) begin
            pickVec = ivs_pkg::VEC_SWI; // [R2] [R11]
        end else if (~iBit & (|maskReq)) begin // [R1] [R13]
            for (int k = ivs_pkg::NMASK - 1; k >= 0; k--) begin
                if (maskReq[k]) begin
                    pickVec = ivs_pkg::VEC_OF[k]; // [R3] [R11]
                end
            end
            for (int k = 0; k < ivs_pkg::NMASK; k++) begin
                if (maskReq[k] && (ivs_pkg::PSEL_OF[k] == psel_ff
                        || (k == ivs_pkg::M_IRQ && psel_ff == ivs_pkg::PSEL_RSVD))) begin
                    pickVec = ivs_pkg::VEC_OF[k]; // [R18]
                end
            end
        end else begin
            anyReq = 1'b0;
        end
    end

    // Sequencer next state: wait, push, vector fetch, or pop
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sp = sp_ff;
        nxt_vec = vec_ff;
        nxt_nmiEntry = nmiEntry_ff;
        nxt_regs = regs_ff;
        nxt_load = 1'b0;
        unique case (state_ff)
            ivs_pkg::IVS_IDLE: begin
                if (resetReq) begin
                    nxt_vec = pickVec;
                    nxt_state = ivs_pkg::IVS_VECHI;
                end else if (returnFromInterrupt) begin
                    nxt_regs = cpuRegs;
                    nxt_sp = stackPointer;
                    nxt_cnt = ivs_pkg::STACK_LAST;
                    nxt_state = ivs_pkg::IVS_POP;
                end else if (anyReq) begin
                    nxt_state = ivs_pkg::IVS_WAIT;
                end
            end
            ivs_pkg::IVS_WAIT: begin
                if (instructionEnd) begin // [R14]
                    nxt_regs = cpuRegs;
                    nxt_sp = stackPointer;
                    nxt_cnt = ivs_pkg::CNT_ZERO;
                    nxt_vec = pickVec;
                    nxt_nmiEntry = pickNmi;
                    nxt_state = anyReq ? ivs_pkg::IVS_PUSH : ivs_pkg::IVS_IDLE;
                end
            end
            ivs_pkg::IVS_PUSH: begin
                nxt_sp = sp_ff - ivs_pkg::ADDR_ONE; // [R20]
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == ivs_pkg::STACK_LAST) begin
                    nxt_regs.conditionCodeRegister[ivs_pkg::I_BIT] = 1'b1; // [R16]
                    if (nmiEntry_ff) begin
                        nxt_regs.conditionCodeRegister[ivs_pkg::X_BIT] = 1'b1; // [R16] [R19]
                    end
                    nxt_state = ivs_pkg::IVS_VECHI;
                end
            end
            ivs_pkg::IVS_VECHI: begin
                nxt_regs.pc[15:8] = memReadData; // [R21]
                nxt_state = ivs_pkg::IVS_VECLO;
            end
            ivs_pkg::IVS_VECLO: begin
                nxt_regs.pc[7:0] = memReadData; // [R21]
                nxt_load = 1'b1;
                nxt_state = ivs_pkg::IVS_IDLE;
            end
            ivs_pkg::IVS_POP: begin
                nxt_sp = sp_ff + ivs_pkg::ADDR_ONE; // [R20]
                nxt_regs = setSlot(regs_ff, cnt_ff, memReadData); // [R17]
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == ivs_pkg::CNT_ZERO) begin
                    nxt_load = 1'b1;
                    nxt_state = ivs_pkg::IVS_IDLE;
                end
            end
            default: nxt_state = ivs_pkg::IVS_IDLE;
        endcase
    end

    // Memory port; pop pre-increments, so it reads one above the pointer
    always_comb begin
        memWrite = 1'b0;
        memRead = 1'b0;
        memAddr = sp_ff;
        memWriteData = ivs_pkg::BYTE_ZERO;
        unique case (state_ff)
            ivs_pkg::IVS_PUSH: begin
                memWrite = 1'b1;
                memWriteData = slotByte(regs_ff, cnt_ff); // [R15]
            end
            ivs_pkg::IVS_VECHI: begin
                memRead = 1'b1;
                memAddr = vec_ff;
            end
            ivs_pkg::IVS_VECLO: begin
                memRead = 1'b1;
                memAddr = vec_ff | ivs_pkg::ADDR_ONE;
            end
            ivs_pkg::IVS_POP: begin
                memRead = 1'b1;
                memAddr = sp_ff + ivs_pkg::ADDR_ONE;
            end
            default: memAddr = sp_ff;
        endcase
    end

    // Priority select only changes while I is set, avoiding races
    always_comb begin
        nxt_psel = psel_ff;
        if (prioritySelectWrite && iBit) begin
            nxt_psel = prioritySelect; // [R18]
        end
        // Data read arms nothing; only a status read with the flag set arms the clear
        nxt_statusSeen = statusSeen_ff;
        if (serialStatusRead) begin
            nxt_statusSeen = flags.receiveFull;
        end else if (serialDataRead) begin
            nxt_statusSeen = 1'b0;
        end
    end

    assign receiveFullClear = statusSeen_ff & serialDataRead & ~serialStatusRead; // [R4]
    assign requestPending = anyReq;
    assign busy = (state_ff != ivs_pkg::IVS_IDLE) && (state_ff != ivs_pkg::IVS_WAIT);
    assign loadRegs = load_ff;
    assign newRegs = regs_ff;
    assign newStackPointer = sp_ff;
    assign prioritySelectOut = psel_ff;

    // State registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_ff <= ivs_pkg::IVS_IDLE;
            cnt_ff <= ivs_pkg::CNT_ZERO;
            sp_ff <= '0;
            vec_ff <= ivs_pkg::VEC_RESET;
            nmiEntry_ff <= 1'b0;
            regs_ff <= '0;
            load_ff <= 1'b0;
            psel_ff <= ivs_pkg::PSEL_RESET; // [R18]
            statusSeen_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sp_ff <= nxt_sp;
            vec_ff <= nxt_vec;
            nmiEntry_ff <= nxt_nmiEntry;
            regs_ff <= nxt_regs;
            load_ff <= nxt_load;
            psel_ff <= nxt_psel;
            statusSeen_ff <= nxt_statusSeen;
        end
    end
endmodule

// [ivs_vector_stack_chk.sv]
// Checker: port timing of interrupt entry, vector fetch and the side paths.
// Assumes cpuRegs stay steady from the end of an instruction until the load strobe.
`timescale 1ns/10ps
module ivs_vector_stack_chk (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic nonmaskablePinRequest,
    input wire logic prioritySelectWrite,
    input wire logic serialStatusRead,
    input wire logic serialDataRead,
    input wire ivs_pkg::ivs_regs_t cpuRegs,
    input wire logic [7:0] memReadData,
    input wire logic requestPending,
    input wire logic busy,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic [15:0] memAddr,
    input wire logic [7:0] memWriteData,
    input wire logic loadRegs,
    input wire ivs_pkg::ivs_regs_t newRegs,
    input wire logic [15:0] newStackPointer,
    input wire logic [3:0] prioritySelectOut,
    input wire logic receiveFullClear
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Entry walk: nine pushes, then the two vector reads, then the load strobe
    sequence pushes_s;
        memWrite [*8];
    endsequence
    sequence fetch_s;
        (memRead && !memWrite) ##1 memRead ##1 loadRegs;
    endsequence
    a_entry_walk: assert property ($rose(memWrite) |-> memWrite ##1 pushes_s ##1 fetch_s)
        else $error("entry walk broken");
    a_push_step: assert property (memWrite && $past(memWrite)
        |-> memAddr == $past(memAddr) - 16'h0001)
        else $error("push address step wrong");
    a_pc_first: assert property ($rose(memWrite) |-> memWriteData == cpuRegs.pc[7:0])
        else $error("first push not program counter low");
    // The flags byte goes out last and still carries the pre-entry mask bits
    a_flags_last: assert property ($rose(memWrite)
        |-> ##8 memWriteData == cpuRegs.conditionCodeRegister)
        else $error("last push not flags byte");
    a_vec_pair: assert property (memRead && !memWrite && $past(memWrite)
        |-> !memAddr[0] ##1 memAddr == $past(memAddr) + 16'h0001)
        else $error("vector read pair wrong");
    a_entry_load: assert property (loadRegs && $past(memWrite, 3)
        |-> newStackPointer == $past(memAddr, 3) - 16'h0001
        && newRegs.pc == {$past(memReadData, 2), $past(memReadData)}
        && newRegs.conditionCodeRegister[ivs_pkg::I_BIT])
        else $error("entry load values wrong");
    a_nmi_wins: assert property (!busy && nonmaskablePinRequest
        && !cpuRegs.conditionCodeRegister[ivs_pkg::X_BIT] |-> requestPending)
        else $error("unmasked pin request not pending");
    // A clear disarms, so two clears never come back to back
    a_rx_clear: assert property (receiveFullClear
        |-> serialDataRead && !serialStatusRead && !$past(receiveFullClear))
        else $error("receive clear without fresh status read");
    a_psel_keep: assert property (prioritySelectWrite
        && !cpuRegs.conditionCodeRegister[ivs_pkg::I_BIT] |=> $stable(prioritySelectOut))
        else $error("priority written while unmasked");
endmodule

bind ivs_vector_stack ivs_vector_stack_chk u_chk (.mclk(mclk), .rstn(rstn),
    .nonmaskablePinRequest(nonmaskablePinRequest), .prioritySelectWrite(prioritySelectWrite),
    .serialStatusRead(serialStatusRead), .serialDataRead(serialDataRead), .cpuRegs(cpuRegs),
    .memReadData(memReadData), .requestPending(requestPending), .busy(busy),
    .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr), .memWriteData(memWriteData),
    .loadRegs(loadRegs), .newRegs(newRegs), .newStackPointer(newStackPointer),
    .prioritySelectOut(prioritySelectOut), .receiveFullClear(receiveFullClear));

// [ivs_cpu_model.sv]
// Partner: CPU instruction boundaries and a combinational byte memory.
// Assumes vectors live in the top page; the table there is fixed by address.
`timescale 1ns/10ps
module ivs_cpu_model (
    input wire logic mclk,
    input wire logic [2:0] gap,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic [15:0] memAddr,
    input wire logic [7:0] memWriteData,
    output logic [7:0] memReadData,
    output logic instructionEnd
);
    logic [7:0] mem [65536];
    logic [7:0] lastData = 8'h00;
    logic [2:0] cnt = 3'h0;
    // Instruction ends at a varying pace, so service latency varies too
    initial instructionEnd = 1'b0;
    always @(negedge mclk) begin
        instructionEnd <= (cnt >= gap);
        cnt <= (cnt >= gap) ? 3'h0 : cnt + 3'h1;
    end
    // Stores land on the edge; idle read data is the inverse of the last byte
    always @(posedge mclk) begin
        if (memWrite) mem[memAddr] <= memWriteData;
        if (memRead) lastData <= memReadData;
    end
    always_comb begin
        if (!memRead) memReadData = ~lastData;
        else if (memAddr[15:8] == 8'hff) memReadData = memAddr[7:0] ^ 8'h5a;
        else memReadData = mem[memAddr];
    end
endmodule

// [ivs_vector_stack_bench.sv]
// Bench: random and corner cases for entry, vectors, return and side paths.
// Assumes the partner model answers memory and marks instruction ends.
`timescale 1ns/10ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module ivs_vector_stack_bench;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    ivs_pkg::ivs_flags_t flg;
    ivs_pkg::ivs_enables_t en;
    ivs_pkg::ivs_regs_t regs;
    logic nmi, ill, swi, wdF, wdDis, cmF, cmEn, por, pWr, stRd, dRd, ret;
    logic [3:0] pSel;
    logic [15:0] sp;
    logic [2:0] gap;
    wire logic pend, busy, mW, mR, ld, rxClr, iEnd;
    wire logic [15:0] mA, nSp;
    wire logic [7:0] mWd, mRd;
    wire logic [3:0] pOut;
    wire ivs_pkg::ivs_regs_t nRegs;
    int errors = 0;
    int samplesChecked = 0;
    int seed;
    int cycles = 0;
    logic [15:0] nmVec [6] = '{16'hfff4, 16'hfff6, 16'hfff8, 16'hfffe, 16'hfffa, 16'hfffc};

    ivs_vector_stack DUT (.mclk(mclk), .rstn(rstn), .flags(flg), .enables(en),
        .nonmaskablePinRequest(nmi), .illegalOpcode(ill), .softwareInterrupt(swi),
        .watchdogFail(wdF), .watchdogDisable(wdDis), .clockMonitorFail(cmF),
        .clockMonitorEnable(cmEn), .powerOnReset(por), .prioritySelect(pSel),
        .prioritySelectWrite(pWr), .serialStatusRead(stRd), .serialDataRead(dRd),
        .instructionEnd(iEnd), .returnFromInterrupt(ret), .cpuRegs(regs), .stackPointer(sp),
        .memReadData(mRd), .requestPending(pend), .busy(busy), .memWrite(mW), .memRead(mR),
        .memAddr(mA), .memWriteData(mWd), .loadRegs(ld), .newRegs(nRegs),
        .newStackPointer(nSp), .prioritySelectOut(pOut), .receiveFullClear(rxClr));
    ivs_cpu_model partner (.mclk(mclk), .gap(gap), .memWrite(mW), .memRead(mR), .memAddr(mA),
        .memWriteData(mWd), .memReadData(mRd), .instructionEnd(iEnd));

    initial forever #2 mclk = ~mclk;
    // Hang guard: the whole run needs under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            endOfTest();
        end
    end

    task automatic endOfTest();
        if (errors == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Flag bit to enable bit: the two receive flags share one enable
    function automatic int enBit(input int f);
        return (f >= 4) ? f - 1 : f;
    endfunction
    function automatic logic [15:0] expVec(input int f);
        if (f == 18) return 16'hfff2;
        if (f == 17) return 16'hfff0;
        if (f >= 14) return 16'hffea + 16'((16 - f) * 2);
        if (f >= 10) return 16'hffe2 + 16'((13 - f) * 2);
        if (f >= 5) return 16'hffe0 - 16'((9 - f) * 2);
        return 16'hffd6;
    endfunction
    function automatic logic [15:0] vecData(input logic [15:0] v);
        return {v[7:0] ^ 8'h5a, (v[7:0] | 8'h01) ^ 8'h5a};
    endfunction

    task automatic waitLoad();
        int n;
        n = 0;
        while (ld !== 1'b1 && n < 64) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK(ld, 1'b1)
    endtask

    // One service: vector load, stack image, then return and restore
    task automatic entry(input logic [15:0] v, input bit stacks, input logic [7:0] mask);
        ivs_pkg::ivs_regs_t r0;
        logic [15:0] sp0;
        r0 = regs;
        sp0 = sp;
        waitLoad();
        `CHK(nRegs.pc, vecData(v))
        @(negedge mclk);
        {flg, nmi, ill, swi, wdF, cmF, por} = '0;
        if (stacks) begin
            `CHK(nSp, sp0 - 16'h0009)
            `CHK(nRegs, {vecData(v), r0[55:8], r0[7:0] | mask})
            `CHK(partner.mem[sp0], r0.pc[7:0])
            `CHK(partner.mem[sp0 - 16'h0008], r0.conditionCodeRegister)
            regs = nRegs;
            sp = nSp;
            ret = 1'b1;
            @(negedge mclk);
            ret = 1'b0;
            `CHK(busy, 1'b1)
            waitLoad();
            `CHK(busy, 1'b0)
            `CHK(nRegs, r0)
            `CHK(nSp, sp0)
            @(negedge mclk);
            regs = r0;
            sp = sp0;
        end
    endtask

    initial begin
        int f;
        seed = 59939;
        {flg, en, regs, nmi, ill, swi, wdF, wdDis, cmF, cmEn, por, pWr, stRd, dRd, ret} = '0;
        pSel = 4'h0;
        sp = 16'h0400;
        gap = 3'h2;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        `CHK(pOut, 4'h6)
        // Each maskable source: local gate (none for IRQ), global gate, then entry and return
        for (f = 0; f < 19; f++) begin
            regs = 72'({$random(seed), $random(seed), $random(seed)});
            regs.conditionCodeRegister = regs.conditionCodeRegister | 8'h50;
            sp = 16'h0100 + 16'($random(seed) & 32'h3fff);
            gap = 3'($random(seed));
            flg = '0;
            flg[f] = 1'b1;
            en = 17'($random(seed));
            if (f != 18) begin
                en[enBit(f)] = 1'b0;
                regs.conditionCodeRegister[4] = 1'b0;
                #0.5;
                `CHK(pend, 1'b0)
                @(negedge mclk);
                regs.conditionCodeRegister[4] = 1'b1;
                en[enBit(f)] = 1'b1;
            end
            #0.5;
            `CHK(pend, 1'b0)
            @(negedge mclk);
            regs.conditionCodeRegister[4] = 1'b0;
            #0.5;
            `CHK(pend, 1'b1)
            entry(expVec(f), 1'b1, 8'h10);
        end
        // Priority select is ignored while unmasked and honoured while masked
        regs.conditionCodeRegister = 8'h00;
        pSel = 4'h3;
        pWr = 1'b1;
        @(negedge mclk);
        pWr = 1'b0;
        `CHK(pOut, 4'h6)
        regs.conditionCodeRegister = 8'h50;
        pSel = 4'hb;
        pWr = 1'b1;
        @(negedge mclk);
        pWr = 1'b0;
        `CHK(pOut, 4'hb)
        flg = '0;
        flg[18] = 1'b1;
        flg[10] = 1'b1;
        en = '0;
        en[9] = 1'b1;
        regs.conditionCodeRegister = 8'h40;
        entry(16'hffe8, 1'b1, 8'h10);
        // Non-maskable and reset-class sources with the I mask set
        for (f = 0; f < 6; f++) begin
            regs.conditionCodeRegister = (f == 0) ? 8'h10 : 8'h50;
            wdDis = 1'b1;
            cmEn = 1'b0;
            case (f)
                0: nmi = 1'b1;
                1: swi = 1'b1;
                2: ill = 1'b1;
                3: por = 1'b1;
                4: wdF = 1'b1;
                default: cmF = 1'b1;
            endcase
            #0.5;
            `CHK(pend, f < 4)
            @(negedge mclk);
            wdDis = 1'b0;
            cmEn = 1'b1;
            entry(nmVec[f], f < 3, (f == 0) ? 8'h50 : 8'h10);
        end
        // Receive-full clears only after a status read with the flag set
        flg = '0;
        flg[4] = 1'b1;
        dRd = 1'b1;
        #0.5;
        `CHK(rxClr, 1'b0)
        @(negedge mclk);
        dRd = 1'b0;
        stRd = 1'b1;
        @(negedge mclk);
        stRd = 1'b0;
        dRd = 1'b1;
        #0.5;
        `CHK(rxClr, 1'b1)
        @(negedge mclk);
        dRd = 1'b0;
        // A second reset must bring the priority select back
        rstn = 1'b0;
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        `CHK(pOut, 4'h6)
        endOfTest();
    end
endmodule
